// >>> verilog/phy_regs_consts.svh
// constants for the 10base operations and extended control registers
// assumes one 50 mhz core clock; included by the register block only
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// ==========================================================
// management frame
`define MDIO_PRE_LEN 6'd32
`define MDIO_OP_READ 2'b10
`define MDIO_OP_WRITE 2'b01
`define PHY_ADDR_DEF 5'h01

// ==========================================================
// register offsets
`define REG_TENB_OPS 5'h12
`define REG_EXT_CTL2 5'h13

// ==========================================================
// 10base operations fields and reset
`define TENB_POL_REV 14
`define TENB_JAB_INH 5
`define TENB_RSV_ONE 4
`define TENB_APOL_INH 3
`define TENB_SQE_INH 2
`define TENB_LINK_INH 1
`define TENB_SQL_INH 0
`define TENB_WR_MASK 16'h003f
`define TENB_RST 16'h0010

// ==========================================================
// extended control fields and reset
`define EXT_NODE_REP 15
`define EXT_PRIO_STRAP 14
`define EXT_RFAULT 13
`define EXT_APD_10 1
`define EXT_APD_100 0
`define EXT_WR_MASK 16'h0003
`define EXT_RST 16'h0003

// ==========================================================
// timing
`define CLK_PERIOD_NS 20
`define SQE_PULSE_NS 1000
`define SQE_PULSE_CYC ((`SQE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_WAIT_CYC 2'd3

`endif

// >>> verilog/phy_mgmt_pkg.sv
// types shared by the management register block
// assumes the constants header for all numeric values
package phy_mgmt_pkg;

  // ==========================================================
  // serial management frame walker
  typedef enum logic [2:0] {
    ms_pre,
    ms_start,
    ms_op,
    ms_addr,
    ms_ta,
    ms_rd,
    ms_wr
  } mdio_state_t;

endpackage

// >>> verilog/sync_two_ff.sv
// two flip-flop synchroniser for pin levels
// assumes inputs are quasi-static or sampled well below core rate
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int W = 1
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule

// >>> verilog/sqe_pulse_gen.sv
// collision test pulse after each transmission ends
// assumes tx enable already synchronised to the core clock
`timescale 1ns/1ps
module sqe_pulse_gen #(
  parameter int CYC = 50
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic tx_en_in,
  input wire logic test_en_in,
  output logic pulse_out
);

  logic tx_en_d_r;
  logic [15:0] cnt_r;

  // ==========================================================
  // end of frame detect and pulse length count
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_en_d_r <= 1'b0;
      cnt_r <= 16'h0000;
      pulse_out <= 1'b0;
    end else begin
      tx_en_d_r <= tx_en_in;
      if (tx_en_d_r && !tx_en_in && test_en_in) begin
        cnt_r <= 16'(CYC);
        pulse_out <= 1'b1;
      end else if (cnt_r > 16'h0001) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r <= 16'h0000;
        pulse_out <= 1'b0;
      end
    end
  end

endmodule

// >>> verilog/phy_10bt_ops_ext_ctrl_regs.sv
// 10base operations and extended control registers with mdio slave
// assumes mdc and mdio come from pins; mode inputs from core logic
//
// Behaviour
// - polarity reversed status reported in latched bit
// - reversed pair handled transparently by receive path
// - jabber checking unless jabber inhibit set
// - auto polarity correction unless inhibit set
// - polarity inhibit also governs 100 mode
// - sqe test generated in 10 mode unless inhibit set
// - collision pulse after transmit enable falls
// - no sqe test in full duplex, repeater
// - inhibit bit keeps value under automatic suppression
// - link loss inhibit forces link passed
// - squelch inhibit requires data then idle
// - node repeater strap read back live
// - repeater defaults sqe off, rx-only carrier sense
// - pin register priority strap read back
// - remote fault mirrors partner fault bit
// - reserved bits read zero, writes ignored, except 10base ops bit 4, which resets to one and is writable
// - 10 transceiver off in 100 mode
// - 100 transceiver off in 10 mode
// - isolate powers down both transceivers
`timescale 1ns/1ps
`include "phy_regs_consts.svh"
module phy_10bt_ops_ext_ctrl_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEF,
  parameter int SQE_CYC = `SQE_PULSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n_out,
  input wire logic node_repeater_strap_in,
  input wire logic pin_register_priority_strap_in,
  input wire logic rx_pol_swapped_in,
  input wire logic rx_active_in,
  input wire logic rx_link_detect_in,
  input wire logic tx_en_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic isolate_in,
  input wire logic remote_fault_in,
  output logic rx_pol_invert_out,
  output logic jabber_check_en_out,
  output logic link_pass_out,
  output logic link_need_idle_out,
  output logic sqe_col_out,
  output logic crs_out,
  output logic pd_10_out,
  output logic pd_100_out
);

  // ==========================================================
  // pin synchronisation
  logic [6:0] pin_s;
  logic mdc_s;
  logic mdio_s;
  logic rep_s;
  logic prio_s;
  logic pol_s;
  logic rxact_s;
  logic txen_s;

  sync_two_ff #(
    .W(7)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({mdc_in, mdio_in, node_repeater_strap_in,
           pin_register_priority_strap_in, rx_pol_swapped_in,
           rx_active_in, tx_en_in}),
    .q_out(pin_s)
  );

  assign mdc_s = pin_s[6];
  assign mdio_s = pin_s[5];
  assign rep_s = pin_s[4];
  assign prio_s = pin_s[3];
  assign pol_s = pin_s[2];
  assign rxact_s = pin_s[1];
  assign txen_s = pin_s[0];

  // mdc rising edge, seen from the synchronised copy only
  logic mdc_d_r;
  logic mdc_rise;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_d_r;

  // ==========================================================
  // register storage
  logic [15:0] tenb_r;
  logic [15:0] ext_r;
  logic pol_latch_r;
  logic [1:0] strap_wait_r;
  logic strap_done_r;
  logic [15:0] rd18_val;
  logic [15:0] rd19_val;

  // frame walker outputs used by the register store
  logic wr_stb_r;
  logic [4:0] wr_reg_r;
  logic [15:0] wr_sh_r;
  logic rd18_stb_r;

  // read views; reserved positions come back as zero, except 10base ops bit 4 from the store
  assign rd18_val = (tenb_r & `TENB_WR_MASK) |
                    (16'(pol_latch_r) << `TENB_POL_REV);
  assign rd19_val = (ext_r & `EXT_WR_MASK) |
                    (16'(rep_s) << `EXT_NODE_REP) |
                    (16'(prio_s) << `EXT_PRIO_STRAP) |
                    (16'(remote_fault_in) << `EXT_RFAULT);

  // strap wait: the synchroniser needs a few edges after release
  // before the strap level is trustworthy
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_wait_r <= 2'd0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_wait_r == `STRAP_WAIT_CYC) begin
        strap_done_r <= 1'b1;
      end else begin
        strap_wait_r <= strap_wait_r + 2'd1;
      end
    end
  end

  // 10base operations control bits
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tenb_r <= `TENB_RST;
    end else if (!strap_done_r && strap_wait_r == `STRAP_WAIT_CYC) begin
      tenb_r[`TENB_SQE_INH] <= rep_s;
    end else if (wr_stb_r && wr_reg_r == `REG_TENB_OPS) begin
      tenb_r <= wr_sh_r & `TENB_WR_MASK;
    end
  end

  // extended control bits; reserved writes are dropped
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_r <= `EXT_RST;
    end else if (wr_stb_r && wr_reg_r == `REG_EXT_CTL2) begin
      ext_r <= wr_sh_r & `EXT_WR_MASK;
    end
  end

  // polarity latch: read clears, a live reversal wins over the clear
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pol_latch_r <= 1'b0;
    end else if (pol_s) begin
      pol_latch_r <= 1'b1;
    end else if (rd18_stb_r) begin
      pol_latch_r <= 1'b0;
    end
  end

  // ==========================================================
  // serial management frame walker
  mdio_state_t st_r;
  logic [5:0] cnt_r;
  logic [5:0] ones_r;
  logic [1:0] op_r;
  logic [9:0] addr_sh_r;
  logic hit_r;
  logic [15:0] rd_sh_r;
  logic [9:0] addr_nxt;
  logic hit_nxt;

  // phy address and register are complete on the last address bit
  assign addr_nxt = {addr_sh_r[8:0], mdio_s};
  assign hit_nxt = (addr_nxt[9:5] == PHY_ADDR) &&
                   (addr_nxt[4:0] == `REG_TENB_OPS ||
                    addr_nxt[4:0] == `REG_EXT_CTL2);

  // walker state, samples on every mdc rise
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= ms_pre;
      cnt_r <= 6'd0;
      ones_r <= 6'd0;
      op_r <= 2'b00;
      addr_sh_r <= 10'h000;
      hit_r <= 1'b0;
    end else if (mdc_rise) begin
      unique case (st_r)
        ms_pre: begin
          if (mdio_s) begin
            if (ones_r != `MDIO_PRE_LEN) begin
              ones_r <= ones_r + 6'd1;
            end
          end else if (ones_r == `MDIO_PRE_LEN) begin
            st_r <= ms_start;
          end else begin
            ones_r <= 6'd0;
          end
        end
        ms_start: begin
          ones_r <= 6'd0;
          cnt_r <= 6'd0;
          st_r <= mdio_s ? ms_op : ms_pre;
        end
        ms_op: begin
          op_r <= {op_r[0], mdio_s};
          if (cnt_r == 6'd1) begin
            st_r <= ms_addr;
            cnt_r <= 6'd0;
          end else begin
            cnt_r <= cnt_r + 6'd1;
          end
        end
        ms_addr: begin
          addr_sh_r <= addr_nxt;
          if (cnt_r == 6'd9) begin
            hit_r <= hit_nxt && (op_r == `MDIO_OP_READ ||
                                 op_r == `MDIO_OP_WRITE);
            st_r <= ms_ta;
            cnt_r <= 6'd0;
          end else begin
            cnt_r <= cnt_r + 6'd1;
          end
        end
        ms_ta: begin
          if (cnt_r == 6'd0) begin
            cnt_r <= 6'd1;
          end else if (op_r == `MDIO_OP_READ) begin
            st_r <= ms_rd;
            cnt_r <= 6'd15;
          end else begin
            st_r <= ms_wr;
            cnt_r <= 6'd0;
          end
        end
        ms_rd: begin
          if (cnt_r == 6'd0) begin
            st_r <= ms_pre;
          end else begin
            cnt_r <= cnt_r - 6'd1;
          end
        end
        ms_wr: begin
          if (cnt_r == 6'd15) begin
            st_r <= ms_pre;
            cnt_r <= 6'd0;
          end else begin
            cnt_r <= cnt_r + 6'd1;
          end
        end
      endcase
    end
  end

  // read snapshot taken as the address completes
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_sh_r <= 16'h0000;
      rd18_stb_r <= 1'b0;
    end else begin
      rd18_stb_r <= 1'b0;
      if (mdc_rise && st_r == ms_addr && cnt_r == 6'd9) begin
        rd_sh_r <= (addr_nxt[4:0] == `REG_TENB_OPS) ? rd18_val : rd19_val;
        rd18_stb_r <= hit_nxt && op_r == `MDIO_OP_READ &&
                      addr_nxt[4:0] == `REG_TENB_OPS;
      end else if (mdc_rise && (st_r == ms_rd ||
                   (st_r == ms_ta && cnt_r == 6'd1))) begin
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
      end
    end
  end

  // mdio driver: turnaround zero, then sixteen bits msb first
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mdio_out <= 1'b1;
      mdio_oe_n_out <= 1'b1;
    end else if (mdc_rise) begin
      if (st_r == ms_ta && hit_r && op_r == `MDIO_OP_READ) begin
        mdio_oe_n_out <= 1'b0;
        mdio_out <= (cnt_r == 6'd0) ? 1'b0 : rd_sh_r[15];
      end else if (st_r == ms_rd && hit_r && cnt_r != 6'd0) begin
        mdio_out <= rd_sh_r[15];
      end else begin
        mdio_oe_n_out <= 1'b1;
        mdio_out <= 1'b1;
      end
    end
  end

  // write data shift and strobe on the last data bit
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_sh_r <= 16'h0000;
      wr_stb_r <= 1'b0;
      wr_reg_r <= 5'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (mdc_rise && st_r == ms_wr) begin
        wr_sh_r <= {wr_sh_r[14:0], mdio_s};
        if (cnt_r == 6'd15) begin
          wr_stb_r <= hit_r;
          wr_reg_r <= addr_sh_r[4:0];
        end
      end
    end
  end

  // ==========================================================
  // sqe test pulse
  logic sqe_en;
  logic sqe_pulse;

  // suppression is computed here and never written back to the bit
  assign sqe_en = !tenb_r[`TENB_SQE_INH] && !full_duplex_in &&
                  !rep_s && !speed_100_in;

  sqe_pulse_gen #(
    .CYC(SQE_CYC)
  ) u_sqe (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .tx_en_in(txen_s),
    .test_en_in(sqe_en),
    .pulse_out(sqe_pulse)
  );

  // ==========================================================
  // derived controls, all registered
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_pol_invert_out <= 1'b0;
      jabber_check_en_out <= 1'b1;
      link_pass_out <= 1'b0;
      link_need_idle_out <= 1'b0;
      sqe_col_out <= 1'b0;
      crs_out <= 1'b0;
      pd_10_out <= 1'b0;
      pd_100_out <= 1'b0;
    end else begin
      // receive path corrects the pair in either speed
      rx_pol_invert_out <= pol_s && !tenb_r[`TENB_APOL_INH];
      jabber_check_en_out <= !tenb_r[`TENB_JAB_INH];
      link_pass_out <= tenb_r[`TENB_LINK_INH] || rx_link_detect_in;
      link_need_idle_out <= tenb_r[`TENB_SQL_INH];
      sqe_col_out <= sqe_pulse;
      crs_out <= rxact_s || (txen_s && !rep_s);
      pd_10_out <= isolate_in ||
                   (ext_r[`EXT_APD_10] && speed_100_in);
      pd_100_out <= isolate_in ||
                    (ext_r[`EXT_APD_100] && !speed_100_in);
    end
  end

endmodule

// >>> sim/phy_regs_checker.sv
// checker for the 10base operations and extended control block
// assumes it sees only the block's ports; bound after the module
`timescale 1ns/1ps
module phy_regs_checker #(
  parameter int SQE_CYC = 50
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n_out,
  input wire logic node_repeater_strap_in,
  input wire logic rx_active_in,
  input wire logic rx_link_detect_in,
  input wire logic tx_en_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic isolate_in,
  input wire logic link_pass_out,
  input wire logic sqe_col_out,
  input wire logic crs_out,
  input wire logic pd_10_out,
  input wire logic pd_100_out
);
  // ==========================================================
  // helper counters
  logic [7:0] hi_cnt_r;
  logic [3:0] since_r;
  // length of the running collision test pulse
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) hi_cnt_r <= 8'h00;
    else hi_cnt_r <= sqe_col_out ? hi_cnt_r + 8'h01 : 8'h00;
  end
  // cycles since tx enable dropped, saturating so it never wraps
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) since_r <= 4'h0;
    else since_r <= tx_en_in ? 4'h0 : (since_r == 4'hf ? since_r : since_r + 4'h1);
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // assertions
  pd_iso_a: assert property (isolate_in |=> pd_10_out && pd_100_out)
    else $error("isolate left a transceiver on");
  pd_ten_a: assert property (!speed_100_in && !isolate_in |=> !pd_10_out)
    else $error("10 transceiver off in 10 mode");
  pd_hundred_a: assert property (speed_100_in && !isolate_in |=> !pd_100_out)
    else $error("100 transceiver off in 100 mode");
  sqe_off_a: assert property ((full_duplex_in || node_repeater_strap_in)[*8]
      |-> !sqe_col_out)
    else $error("collision test while suppressed");
  sqe_len_a: assert property ($fell(sqe_col_out) |-> hi_cnt_r == SQE_CYC)
    else $error("collision test pulse length wrong");
  sqe_cause_a: assert property ($rose(sqe_col_out) |-> !tx_en_in &&
      since_r >= 4'h2 && since_r <= 4'h8)
    else $error("collision test without end of transmit");
  crs_rep_a: assert property ((node_repeater_strap_in && !rx_active_in)[*5] |-> !crs_out)
    else $error("carrier sense without receive in repeater");
  crs_rx_a: assert property (rx_active_in[*5] |-> crs_out)
    else $error("carrier sense missing on receive");
  link_pass_a: assert property (rx_link_detect_in |=> link_pass_out)
    else $error("link not passed on detect");
  ta_zero_a: assert property ($fell(mdio_oe_n_out) |-> !mdio_out)
    else $error("turnaround bit not zero");
  cover property ($rose(sqe_col_out));
  cover property ($fell(mdio_oe_n_out));
  cover property (pd_10_out && pd_100_out);
endmodule

bind phy_10bt_ops_ext_ctrl_regs phy_regs_checker #(.SQE_CYC(SQE_CYC)) chk (
  .core_clk_in, .sys_rst_in, .mdio_out, .mdio_oe_n_out, .node_repeater_strap_in,
  .rx_active_in, .rx_link_detect_in, .tx_en_in, .speed_100_in, .full_duplex_in,
  .isolate_in, .link_pass_out, .sqe_col_out, .crs_out, .pd_10_out, .pd_100_out);

// >>> sim/mgmt_station.sv
// station management model driving the serial management pins
// assumes a pull-up on the data line, resolved by the bench
`timescale 1ns/1ps
module mgmt_station (
  input wire logic core_clk_in,
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_drv_out,
  output logic mdio_oe_n_out,
  output logic [15:0] rd_data_out,
  output logic rd_tog_out
);
  // ==========================================================
  // idle: clock parked low, line released
  initial begin
    mdc_out = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_oe_n_out = 1'b1;
    rd_data_out = 16'h0000;
    rd_tog_out = 1'b0;
  end
  // one frame of 64 periods, 10 core cycles each; sample at every rise
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] f;
    logic [15:0] q;
    f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
    q = 16'h0000;
    @(posedge core_clk_in);
    #1;
    for (int i = 63; i >= 0; i--) begin
      mdc_out = 1'b0;
      mdio_oe_n_out = rd && i < 18;
      mdio_drv_out = f[i];
      #100;
      mdc_out = 1'b1;
      q = {q[14:0], mdio_in};
      #100;
    end
    mdc_out = 1'b0;
    mdio_oe_n_out = 1'b1;
    if (rd) begin
      rd_data_out = q;
      rd_tog_out = ~rd_tog_out;
    end
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the 10base operations and extended control block
// assumes the station model and the bound checker
`timescale 1ns/1ps
module tb;
  localparam int SQE = 4;
  logic clk, rst, rep, prio, pol_sw, rx_act, lk, tx_en, spd, dup, iso, rf;
  logic mdc, mdio_w, d_mdio, d_oe_n, s_mdio, s_oe_n, rd_tog;
  logic jab, pinv, lpass, lidle, sqe, crs, pd10, pd100;
  logic [15:0] rd_data, v;
  logic [15:0] exp_q[$];
  int mismatches, n_checks, hi;
  int seed = 32'h21cb;

  // ==========================================================
  // wiring: pulled-up data line, block drive wins
  assign mdio_w = !d_oe_n ? d_mdio : (!s_oe_n ? s_mdio : 1'b1);
  phy_10bt_ops_ext_ctrl_regs #(.SQE_CYC(SQE)) dut (
    .core_clk_in(clk), .sys_rst_in(rst), .mdc_in(mdc), .mdio_in(mdio_w),
    .mdio_out(d_mdio), .mdio_oe_n_out(d_oe_n), .node_repeater_strap_in(rep),
    .pin_register_priority_strap_in(prio), .rx_pol_swapped_in(pol_sw),
    .rx_active_in(rx_act), .rx_link_detect_in(lk), .tx_en_in(tx_en),
    .speed_100_in(spd), .full_duplex_in(dup), .isolate_in(iso), .remote_fault_in(rf),
    .rx_pol_invert_out(pinv), .jabber_check_en_out(jab), .link_pass_out(lpass),
    .link_need_idle_out(lidle), .sqe_col_out(sqe), .crs_out(crs),
    .pd_10_out(pd10), .pd_100_out(pd100));
  mgmt_station sta (
    .core_clk_in(clk), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_drv_out(s_mdio),
    .mdio_oe_n_out(s_oe_n), .rd_data_out(rd_data), .rd_tog_out(rd_tog));

  // 50 mhz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    sta.xfer(1'b1, ra, 16'h0000);
    step(4);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    sta.xfer(1'b0, ra, d);
    step(4);
  endtask
  // one transmission, then count collision test cycles
  task automatic tx_pulse(output int n);
    tx_en = 1'b1;
    step(8);
    check(16'(crs), 16'(!rep));
    tx_en = 1'b0;
    n = 0;
    repeat (20) begin
      step(1);
      // an unknown collision level counts as a pulse cycle, so it cannot hide
      if (sqe !== 1'b0) n++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // each read result against the oldest noted expectation
  always @(rd_tog) begin
    if (exp_q.size() != 0) check(rd_data, exp_q.pop_front());
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rep, pol_sw, rx_act, lk, tx_en, spd, dup, iso} = 8'h00;
    rst = 1'b1;
    prio = 1'b1;
    rf = 1'b1;
    mismatches = 0;
    n_checks = 0;
    step(12);
    rst = 1'b0;
    step(8);
    rd(5'h12, 16'h0010);
    rd(5'h13, 16'h6003);
    rd(5'h14, 16'hffff);
    // a write to a foreign register must leave the 10base operations register alone
    wr(5'h14, 16'h0000);
    rd(5'h12, 16'h0010);
    // random controls with the pair reversed, mode varied
    pol_sw = 1'b1;
    repeat (6) begin
      v = 16'h0010 | (16'($random(seed)) & 16'h002f);
      {spd, lk} = 2'($random(seed));
      wr(5'h12, v);
      check(16'(jab), 16'(!v[5]));
      check(16'(pinv), 16'(!v[3]));
      check(16'(lpass), 16'(v[1] | lk));
      check(16'(lidle), 16'(v[0]));
      rd(5'h12, v | 16'h4000);
    end
    pol_sw = 1'b0;
    rd(5'h12, v | 16'h4000);
    rd(5'h12, v);
    // power-down enables against speed, partner fault mirrored
    for (int w = 0; w < 4; w++) begin
      rf = w[0];
      wr(5'h13, 16'(w));
      rd(5'h13, 16'h4000 | 16'(w) | {2'b00, rf, 13'h0000});
      for (int s = 0; s < 2; s++) begin
        spd = s[0];
        step(3);
        check(16'(pd10), 16'(w[1] & s[0]));
        check(16'(pd100), 16'(w[0] & !s[0]));
      end
    end
    wr(5'h13, 16'h0000);
    iso = 1'b1;
    step(3);
    check(16'({pd10, pd100}), 16'h0003);
    iso = 1'b0;
    // collision test: enabled, inhibited, full duplex
    spd = 1'b0;
    for (int i = 0; i < 3; i++) begin
      v = (i == 1) ? 16'h0014 : 16'h0010;
      wr(5'h12, v);
      dup = (i == 2);
      tx_pulse(hi);
      check(16'(hi), (i == 0) ? 16'(SQE) : 16'h0000);
      rd(5'h12, v);
    end
    dup = 1'b0;
    rx_act = 1'b1;
    step(8);
    check(16'(crs), 16'h0001);
    rx_act = 1'b0;
    // repeater strap read live, then a reset loads its default
    rep = 1'b1;
    prio = 1'b0;
    step(4);
    rd(5'h13, 16'ha000);
    tx_pulse(hi);
    check(16'(hi), 16'h0000);
    rst = 1'b1;
    step(12);
    rst = 1'b0;
    step(8);
    rd(5'h12, 16'h0014);
    rd(5'h13, 16'ha003);
    check(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule
